// [hw/rmq_dev.sv]
// Device end: measurement control, correction value, pin selectors and primary flags.
`timescale 1ns/100ps
`default_nettype none
module rmq_dev (
    input  wire logic             clk,
    input  wire logic             rstn,
    rmq_if.dev                    bus,
    input  wire rmq_pkg::rmq_mode_e mode,
    input  wire logic             continuous_mode,
    input  wire logic             intermediate_state,
    input  wire logic             osc_running,
    input  wire logic             loop_locked,
    input  wire logic             ramp_done,
    input  wire logic             gain_done,
    input  wire logic             level_sample_valid,
    input  wire logic [7:0]       level_sample,
    input  wire logic [7:0]       level_trip_point,
    input  wire logic [15:0]      error_sample,
    input  wire logic             correction_sample_valid,
    input  wire logic [15:0]      correction_sample,
    input  wire logic             receive_start_deadline,
    input  wire logic             post_trip_deadline,
    input  wire logic             sync_detected,
    input  wire logic             fifo_emptied,
    output logic [15:0]           correction_amount,
    output logic [11:0]           pin_functions,
    output logic [2:0]            clock_output_divider,
    output logic                  rc_osc_enable,
    output logic                  receiver_start
);
    import rmq_pkg::*;

    typedef struct packed {
        logic [7:0]  rdata;
        rmq_mode_e   mode_q;
        logic        auto_zero;
        logic        on_rx;
        logic        quick_wake;
        logic [15:0] corr;
        logic [15:0] err;
        logic [7:0]  lvl;
        logic [7:0]  pin_a;
        logic [3:0]  pin45;
        logic        est_seen;
        logic [2:0]  clkdiv;
        logic [7:0]  flags;
        logic [1:0]  over_cnt;
        logic        rx_start;
        logic        rc_en;
    } rmq_dev_s;

    rmq_dev_s st;
    rmq_dev_s next_st;

    logic est_start;
    logic est_busy;
    logic est_fin;
    logic corr_start;
    logic corr_busy;
    logic lvl_start;
    logic lvl_busy;
    logic rx_entry;
    logic auto_corr_entry;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = bus.wr && (bus.addr == a);
    endfunction : wr_at

    assign rx_entry        = (mode == RMQ_RX) && (st.mode_q != RMQ_RX);
    assign auto_corr_entry = rx_entry && st.on_rx;
    // The strobes sit in a process so that they follow the bus signals read inside the decode function.
    always_comb begin
        // [RL1] Estimate start strobe.
        est_start  = wr_at(ADDR_FCE_CTRL) && bus.wdata[BIT_EST_TRIG];
        // [RL2] [RL3] Correction start strobe.
        corr_start = (wr_at(ADDR_FCE_CTRL) && bus.wdata[BIT_CORR_TRIG] && !st.on_rx) || auto_corr_entry;
        // [RL9] Level start strobe.
        lvl_start  = wr_at(ADDR_LVL_CFG) && bus.wdata[BIT_LVL_TRIG];
    end

    rmq_meas u_est (
        .clk    (clk),
        .rstn   (rstn),
        .start  (est_start),
        .busy   (est_busy),
        .finish (est_fin)
    );
    rmq_meas u_corr (
        .clk    (clk),
        .rstn   (rstn),
        .start  (corr_start),
        .busy   (corr_busy),
        .finish ()
    );
    rmq_meas u_lvl (
        .clk    (clk),
        .rstn   (rstn),
        .start  (lvl_start),
        .busy   (lvl_busy),
        .finish ()
    );

    always_comb begin
        next_st = st;
        next_st.mode_q = mode;
        next_st.rx_start = 1'b0;

        // [RL6] Correction bytes writable.
        if (wr_at(ADDR_CORR_HIGH)) begin
            next_st.corr[15:8] = bus.wdata;
        end else if (wr_at(ADDR_CORR_LOW)) begin
            next_st.corr[7:0] = bus.wdata;
        end else if (wr_at(ADDR_FCE_CTRL)) begin
            next_st.auto_zero = bus.wdata[BIT_AUTO_ZERO];
            next_st.on_rx     = bus.wdata[BIT_ON_RX];
        end else if (wr_at(ADDR_LVL_CFG)) begin
            next_st.quick_wake = bus.wdata[BIT_QUICK_WAKE];
        end else if (wr_at(ADDR_PIN_A)) begin
            // [RL11] Pin selectors stored.
            next_st.pin_a = bus.wdata;
        end else if (wr_at(ADDR_PIN_B)) begin
            next_st.pin45  = bus.wdata[7:4];
            next_st.clkdiv = bus.wdata[2:0];
        end

        // Corrections landed from the analog engine take effect as soon as a valid sample arrives while the correction runs.
        if (corr_busy && correction_sample_valid) begin
            next_st.corr = correction_sample;
        end
        // [RL4] Auto-zero before phase.
        if (auto_corr_entry && st.auto_zero) begin
            next_st.corr = 16'h0000;
        end
        // [RL5] Zero command.
        if (wr_at(ADDR_FCE_CTRL) && bus.wdata[BIT_ZERO_CMD]) begin
            next_st.corr = 16'h0000;
        end
        // [RL1] Done stays low until an estimate ends.
        if (est_start) begin
            next_st.est_seen = 1'b1;
        end
        // [RL7] Offset captured at completion.
        if (est_fin) begin
            next_st.err = error_sample;
        end
        // [RL10] Level reading update.
        if (level_sample_valid) begin
            next_st.lvl = level_sample;
        end

        // [RL12] Internal oscillator follows code 110.
        next_st.rc_en = (st.clkdiv == CLK_DIV_RC);

        // [RL8] Receiver wakeup needs one or two samples over trip point.
        if (mode != RMQ_RX) begin
            next_st.over_cnt = 2'h0;
        end else if (level_sample_valid) begin
            if (level_sample < level_trip_point) begin
                if (st.over_cnt != 2'h2) begin
                    next_st.over_cnt = st.over_cnt + 2'h1;
                end
            end else begin
                next_st.over_cnt = 2'h0;
            end
        end
        next_st.rx_start = (mode == RMQ_RX) && level_sample_valid && (level_sample < level_trip_point)
                           && (st.quick_wake ? (st.over_cnt == 2'h0) : (st.over_cnt == 2'h1));

        // [RL13] Mode ready.
        if (mode != st.mode_q) begin
            next_st.flags[BIT_MODE_RDY] = 1'b0;
        end else begin
            case (mode)
                RMQ_SLEEP:   next_st.flags[BIT_MODE_RDY] = 1'b1;
                RMQ_STANDBY: next_st.flags[BIT_MODE_RDY] = st.flags[BIT_MODE_RDY] | osc_running;
                RMQ_SYNTH:   next_st.flags[BIT_MODE_RDY] = st.flags[BIT_MODE_RDY] | loop_locked;
                RMQ_RX:      next_st.flags[BIT_MODE_RDY] = st.flags[BIT_MODE_RDY] | level_sample_valid;
                RMQ_TX:      next_st.flags[BIT_MODE_RDY] = st.flags[BIT_MODE_RDY] | ramp_done;
                default:     next_st.flags[BIT_MODE_RDY] = 1'b0;
            endcase
        end
        // [RL14] Receive ready.
        next_st.flags[BIT_RX_RDY] = (mode == RMQ_RX) && (st.flags[BIT_RX_RDY]
            || (st.flags[BIT_MODE_RDY] && gain_done && !corr_busy && !corr_start && !rx_entry));
        // [RL15] Transmit ready.
        next_st.flags[BIT_TX_RDY] = (mode == RMQ_TX) && (st.flags[BIT_TX_RDY] || ramp_done);
        // [RL16] Lock follows loop.
        next_st.flags[BIT_LOCK] = loop_locked && (mode == RMQ_SYNTH || mode == RMQ_RX || mode == RMQ_TX);
        // [RL17] [RL21] Trip flag; set wins over clear.
        if (mode != RMQ_RX) begin
            next_st.flags[BIT_TRIP] = 1'b0;
        end else if (level_sample_valid && level_sample < level_trip_point) begin
            next_st.flags[BIT_TRIP] = 1'b1;
        end else if (wr_at(ADDR_FLAGS) && bus.wdata[BIT_TRIP]) begin
            next_st.flags[BIT_TRIP] = 1'b0;
        end
        // [RL18] Timeout flag.
        if (receive_start_deadline || post_trip_deadline) begin
            next_st.flags[BIT_TIMEOUT] = 1'b1;
        end else if (mode != RMQ_RX || fifo_emptied) begin
            next_st.flags[BIT_TIMEOUT] = 1'b0;
        end
        // [RL19] Intermediate state flag.
        next_st.flags[BIT_INTERM] = intermediate_state;
        // [RL20] [RL21] Match flag.
        if (sync_detected && mode == RMQ_RX) begin
            next_st.flags[BIT_MATCH] = 1'b1;
        end else if (mode != RMQ_RX || fifo_emptied) begin
            next_st.flags[BIT_MATCH] = 1'b0;
        end else if (continuous_mode && wr_at(ADDR_FLAGS) && bus.wdata[BIT_MATCH]) begin
            next_st.flags[BIT_MATCH] = 1'b0;
        end

        // Read data stand one cycle after the strobe; triggers read as zero.
        next_st.rdata = 8'h00;
        if (bus.rd) begin
            if (bus.addr == ADDR_FCE_CTRL) begin
                // [RL1] [RL2] Done bits.
                next_st.rdata = {1'b0, st.est_seen && !est_busy, 1'b0, !corr_busy, st.auto_zero, st.on_rx, 2'b00};
            end else if (bus.addr == ADDR_CORR_HIGH) begin
                next_st.rdata = st.corr[15:8];
            end else if (bus.addr == ADDR_CORR_LOW) begin
                next_st.rdata = st.corr[7:0];
            end else if (bus.addr == ADDR_ERR_HIGH) begin
                next_st.rdata = st.err[15:8];
            end else if (bus.addr == ADDR_ERR_LOW) begin
                next_st.rdata = st.err[7:0];
            end else if (bus.addr == ADDR_LVL_CFG) begin
                // [RL9] Level done bit.
                next_st.rdata = {4'h0, st.quick_wake, 1'b0, !lvl_busy, 1'b0};
            end else if (bus.addr == ADDR_LVL_READ) begin
                next_st.rdata = st.lvl;
            end else if (bus.addr == ADDR_PIN_A) begin
                next_st.rdata = st.pin_a;
            end else if (bus.addr == ADDR_PIN_B) begin
                next_st.rdata = {st.pin45, 1'b0, st.clkdiv};
            end else if (bus.addr == ADDR_FLAGS) begin
                next_st.rdata = st.flags;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st        <= '0;
            st.mode_q <= RMQ_SLEEP;
            st.corr   <= RST_CORR;
            st.lvl    <= RST_LVL_READ;
            st.clkdiv <= RST_CLK_DIV;
            st.flags  <= RST_FLAGS;
        end else begin
            st <= next_st;
        end
    end

    assign bus.rdata            = st.rdata;
    assign correction_amount    = st.corr;
    assign pin_functions        = {st.pin_a, st.pin45};
    assign clock_output_divider = st.clkdiv;
    assign rc_osc_enable        = st.rc_en;
    assign receiver_start       = st.rx_start;
endmodule : rmq_dev
`default_nettype wire

// [hw/rmq_pkg.sv]
// Package with register map, field positions, reset values and types of the measurement and flag register bank.
//
// Functional notes
// [RL1] Error estimate trigger starts it; done shows completion.
// [RL2] Correction trigger starts correction; done bit tracks it. The code ignores the trigger while auto mode is on.
// [RL3] Auto mode runs correction on receive entry.
// [RL4] Auto-zero clears correction before each auto phase.
// [RL5] Zero command clears the 16-bit correction value.
// [RL6] Correction value: two RW bytes, reset zero.
// [RL7] Measured offset: two read-only bytes.
// [RL8] Quick wakeup needs one sample, else two.
// [RL9] Level trigger starts measurement; done bit tracks it.
// [RL10] Level reading read-only, resets to 0xff.
// [RL11] Six 2-bit pin selectors, reset zero.
// [RL12] Clock output divider code, reset 111 off.
// [RL13] Mode ready set on reaching mode, cleared on change.
// [RL14] Receive ready after level, gain and correction.
// [RL15] Transmit ready after amplifier ramp-up.
// [RL16] Lock flag follows loop lock in active modes.
// [RL17] Level trip flag set in receive, clears leaving.
// [RL18] Timeout flag set on either receive deadline.
// [RL19] Intermediate flag follows intermediate state.
// [RL20] Match flag set on sync, clearable in continuous.
// [RL21] Clearable flags cleared by writing one only.
package rmq_pkg;
    localparam logic [7:0] ADDR_FCE_CTRL  = 8'h1e;
    localparam logic [7:0] ADDR_CORR_HIGH = 8'h1f;
    localparam logic [7:0] ADDR_CORR_LOW  = 8'h20;
    localparam logic [7:0] ADDR_ERR_HIGH  = 8'h21;
    localparam logic [7:0] ADDR_ERR_LOW   = 8'h22;
    localparam logic [7:0] ADDR_LVL_CFG   = 8'h23;
    localparam logic [7:0] ADDR_LVL_READ  = 8'h24;
    localparam logic [7:0] ADDR_PIN_A     = 8'h25;
    localparam logic [7:0] ADDR_PIN_B     = 8'h26;
    localparam logic [7:0] ADDR_FLAGS     = 8'h27;

    localparam int BIT_EST_DONE   = 6;
    localparam int BIT_EST_TRIG   = 5;
    localparam int BIT_CORR_DONE  = 4;
    localparam int BIT_AUTO_ZERO  = 3;
    localparam int BIT_ON_RX      = 2;
    localparam int BIT_ZERO_CMD   = 1;
    localparam int BIT_CORR_TRIG  = 0;
    localparam int BIT_QUICK_WAKE = 3;
    localparam int BIT_LVL_DONE   = 1;
    localparam int BIT_LVL_TRIG   = 0;
    localparam int BIT_MODE_RDY   = 7;
    localparam int BIT_RX_RDY     = 6;
    localparam int BIT_TX_RDY     = 5;
    localparam int BIT_LOCK       = 4;
    localparam int BIT_TRIP       = 3;
    localparam int BIT_TIMEOUT    = 2;
    localparam int BIT_INTERM     = 1;
    localparam int BIT_MATCH      = 0;

    localparam logic [7:0]  RST_LVL_READ = 8'hff;
    localparam logic [2:0]  RST_CLK_DIV  = 3'h7;
    localparam logic [15:0] RST_CORR     = 16'h0000;
    localparam logic [7:0]  RST_FLAGS    = 8'h80;

    localparam logic [2:0] CLK_DIV_RC  = 3'h6;
    localparam logic [2:0] CLK_DIV_OFF = 3'h7;

    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned MEAS_TIME_NS = 2000;
    localparam int unsigned MEAS_CYCLES  = (MEAS_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0]  MEAS_CNT     = 8'(MEAS_CYCLES);

    typedef enum logic [2:0] {
        RMQ_SLEEP   = 3'h0,
        RMQ_STANDBY = 3'h1,
        RMQ_SYNTH   = 3'h2,
        RMQ_TX      = 3'h3,
        RMQ_RX      = 3'h4
    } rmq_mode_e;
endpackage : rmq_pkg

// [hw/rmq_if.sv]
// Interface joining the host controller and the register bank.
`timescale 1ns/100ps
`default_nettype none
interface rmq_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata
    );
    modport dev (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata
    );
endinterface : rmq_if
`default_nettype wire

// [hw/rmq_meas.sv]
// Measurement sequencer: busy for a fixed count after a start, then done.
`timescale 1ns/100ps
`default_nettype none
module rmq_meas (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      busy,
    output logic      finish
);
    import rmq_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       busy;
        logic       finish;
    } rmq_meas_s;

    rmq_meas_s st;
    rmq_meas_s next_st;

    always_comb begin
        next_st = st;
        next_st.finish = 1'b0;
        if (start) begin
            next_st.busy = 1'b1;
            next_st.cnt  = MEAS_CNT;
        end else if (st.busy) begin
            if (st.cnt <= 8'h01) begin
                next_st.busy   = 1'b0;
                next_st.finish = 1'b1;
                next_st.cnt    = 8'h00;
            end else begin
                next_st.cnt = st.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy   = st.busy;
    assign finish = st.finish;
endmodule : rmq_meas
`default_nettype wire

// [hw/rmq_host.sv]
// Host end: drives single register reads and writes and returns read data.
`timescale 1ns/100ps
`default_nettype none
module rmq_host (
    input  wire logic       clk,
    input  wire logic       rstn,
    rmq_if.host             bus,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    output logic [7:0]      cmd_rdata,
    output logic            cmd_rvalid
);
    import rmq_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       pend;
        logic [7:0] rdata;
        logic       rvalid;
    } rmq_host_s;

    rmq_host_s st;
    rmq_host_s next_st;

    always_comb begin
        next_st = st;
        next_st.wr     = 1'b0;
        next_st.rd     = 1'b0;
        next_st.rvalid = 1'b0;
        // Write wins if both are requested; the bus never carries both strobes.
        // [RL1] [RL2] [RL5] [RL9] [RL21] Triggers and clears are one-cycle writes of one.
        if (cmd_wr) begin
            next_st.wr    = 1'b1;
            next_st.addr  = cmd_addr;
            next_st.wdata = cmd_wdata;
        end else if (cmd_rd) begin
            next_st.rd   = 1'b1;
            next_st.addr = cmd_addr;
        end
        next_st.pend  = st.rd;
        if (st.pend) begin
            next_st.rdata  = bus.rdata;
            next_st.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.addr   = st.addr;
    assign bus.wdata  = st.wdata;
    assign bus.wr     = st.wr;
    assign bus.rd     = st.rd;
    assign cmd_rdata  = st.rdata;
    assign cmd_rvalid = st.rvalid;
endmodule : rmq_host
`default_nettype wire

// [tb/rmq_asserts.sv]
// Checker of bus relations between the host and device ends of the register bank.
`timescale 1ns/100ps
`default_nettype none
module rmq_asserts
    import rmq_pkg::*;
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    import rmq_pkg::*;
    logic auto_q;
    // The correction trigger is ignored while auto mode is on, so the busy check must know that bit.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            auto_q <= 1'b0;
        end else if (wr && addr == ADDR_FCE_CTRL) begin
            auto_q <= wdata[BIT_ON_RX];
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    trig_read_zero_a:
        assert property (rd && addr == ADDR_FCE_CTRL |=> rdata[5] == 1'b0 && rdata[1:0] == 2'h0)
        else $error("trigger bits read back as one");
    lvl_trig_zero_a:
        assert property (rd && addr == ADDR_LVL_CFG |=> rdata[0] == 1'b0) else $error("level trigger reads one");
    est_busy_a:
        assert property ((wr && addr == ADDR_FCE_CTRL && wdata[BIT_EST_TRIG]) ##1 (rd && addr == ADDR_FCE_CTRL)
        |=> !rdata[BIT_EST_DONE]) else $error("estimate done high while running");
    corr_busy_a:
        assert property ((wr && addr == ADDR_FCE_CTRL && wdata[0] && !wdata[2] && !auto_q)
        ##1 (rd && addr == ADDR_FCE_CTRL) |=> !rdata[BIT_CORR_DONE]) else $error("correction done high while running");
    lvl_busy_a:
        assert property ((wr && addr == ADDR_LVL_CFG && wdata[BIT_LVL_TRIG]) ##1 (rd && addr == ADDR_LVL_CFG)
        |=> !rdata[BIT_LVL_DONE]) else $error("level done high while sampling");
    zero_cmd_a:
        assert property ((wr && addr == ADDR_FCE_CTRL && wdata[BIT_ZERO_CMD]) ##1 (rd && addr == ADDR_CORR_HIGH)
        |=> rdata == 8'h00) else $error("correction not zeroed");
    corr_rw_a:
        assert property ((wr && addr == ADDR_CORR_LOW) ##1 (rd && addr == ADDR_CORR_LOW)
        |=> rdata == $past(wdata, 2)) else $error("correction low byte lost");
    pin_a_rw_a:
        assert property ((wr && addr == ADDR_PIN_A) ##1 (rd && addr == ADDR_PIN_A)
        |=> rdata == $past(wdata, 2)) else $error("pin selectors lost");
    pin_b_rsvd_a:
        assert property (rd && addr == ADDR_PIN_B |=> rdata[3] == 1'b0) else $error("unused pin bit reads one");
endmodule : rmq_asserts
`default_nettype wire

// [tb/tb_rx_measure_irq_status_regs.sv]
// Testbench joining host and device ends and checking the register bank through host commands.
`timescale 1ns/100ps
`default_nettype none
module tb_rx_measure_irq_status_regs;
    import rmq_pkg::*;
    logic        clk;
    logic        rstn;
    logic        cont;
    logic        interm;
    logic        osc;
    logic        lock;
    logic        ramp;
    logic        gain;
    logic [5:0]  ev;
    logic [7:0]  lvl_s;
    logic [7:0]  trip;
    logic [15:0] err_s;
    logic [15:0] corr_s;
    logic [15:0] corr_amt;
    logic [11:0] pin_fn;
    logic [2:0]  clk_div;
    logic        rc_en;
    logic        rx_go;
    logic [7:0]  cmd_addr;
    logic [7:0]  cmd_wdata;
    logic        cmd_wr;
    logic        cmd_rd;
    logic [7:0]  cmd_rdata;
    logic        cmd_rvalid;
    rmq_mode_e   mode;
    int          err_total;
    int          checks;

    rmq_if rmq_if_inst ();
    rmq_host rmq_host_inst (.clk(clk), .rstn(rstn), .bus(rmq_if_inst.host), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid));
    rmq_dev rmq_dev_inst (.clk(clk), .rstn(rstn), .bus(rmq_if_inst.dev), .mode(mode), .continuous_mode(cont),
        .intermediate_state(interm), .osc_running(osc), .loop_locked(lock), .ramp_done(ramp), .gain_done(gain),
        .level_sample_valid(ev[0]), .level_sample(lvl_s), .level_trip_point(trip), .error_sample(err_s),
        .correction_sample_valid(ev[1]), .correction_sample(corr_s), .receive_start_deadline(ev[2]),
        .post_trip_deadline(ev[3]), .sync_detected(ev[4]), .fifo_emptied(ev[5]), .correction_amount(corr_amt),
        .pin_functions(pin_fn), .clock_output_divider(clk_div), .rc_osc_enable(rc_en), .receiver_start(rx_go));
    rmq_asserts rmq_asserts_inst (.clk(clk), .rstn(rstn), .addr(rmq_if_inst.addr), .wdata(rmq_if_inst.wdata),
        .wr(rmq_if_inst.wr), .rd(rmq_if_inst.rd), .rdata(rmq_if_inst.rdata));

    always #20 clk = ~clk;

    task automatic close_out();
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // The wr, chk and pulse tasks start and end at a rising edge so writes and reads can run back to back.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        d = 8'hxx;
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk);
        cmd_rd <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            #1;
            if (cmd_rvalid === 1'b1) begin
                d = cmd_rdata;
                break;
            end
        end
        @(posedge clk);
        checks++;
        if ((d & m) !== e) begin
            err_total++;
            $display("[FAIL] t=%0t addr %h got %h exp %h", $time, a, d & m, e);
        end
    endtask : chk

    task automatic cmpv(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmpv

    // Bits of ev: level sample, correction sample, start deadline, trip deadline, sync, fifo emptied.
    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
    endtask : pulse

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        close_out();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        mode = RMQ_SLEEP;
        {cont, interm, osc, lock, ramp, gain, ev, cmd_wr, cmd_rd} = '0;
        {lvl_s, trip, cmd_addr, cmd_wdata, err_s, corr_s} = '0;
        err_total = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(ADDR_FCE_CTRL, 8'hff, 8'h10);
        chk(ADDR_CORR_HIGH, 8'hff, 8'h00);
        chk(ADDR_LVL_CFG, 8'hff, 8'h02);
        chk(ADDR_LVL_READ, 8'hff, RST_LVL_READ);
        chk(ADDR_PIN_A, 8'hff, 8'h00);
        chk(ADDR_PIN_B, 8'hff, 8'h07);
        chk(ADDR_FLAGS, 8'hff, RST_FLAGS);
        wr(ADDR_CORR_HIGH, 8'ha5);
        wr(ADDR_CORR_LOW, 8'h5a);
        chk(ADDR_CORR_LOW, 8'hff, 8'h5a);
        cmpv(corr_amt, 16'ha55a);
        wr(ADDR_PIN_A, 8'he4);
        chk(ADDR_PIN_A, 8'hff, 8'he4);
        wr(ADDR_PIN_B, 8'hde);
        chk(ADDR_PIN_B, 8'hff, 8'hd6);
        cmpv({11'h000, clk_div, 1'b0, rc_en}, {11'h000, CLK_DIV_RC, 2'h1});
        cmpv({4'h0, pin_fn}, 16'h0e4d);
        wr(ADDR_PIN_B, 8'h07);
        chk(ADDR_PIN_B, 8'h07, 8'h07);
        cmpv({12'h000, clk_div, rc_en}, {12'h000, CLK_DIV_OFF, 1'b0});
        // Zero command, then the trigger bits must read back as zero.
        wr(ADDR_FCE_CTRL, 8'h02);
        chk(ADDR_CORR_HIGH, 8'hff, 8'h00);
        chk(ADDR_CORR_LOW, 8'hff, 8'h00);
        chk(ADDR_FCE_CTRL, 8'hff, 8'h10);
        err_s <= 16'h8123;
        wr(ADDR_FCE_CTRL, 8'h20);
        chk(ADDR_FCE_CTRL, 8'h40, 8'h00);
        repeat (MEAS_CYCLES) @(posedge clk);
        chk(ADDR_FCE_CTRL, 8'h40, 8'h40);
        wr(ADDR_ERR_HIGH, 8'h00);
        wr(8'h10, 8'hff);
        chk(ADDR_ERR_HIGH, 8'hff, 8'h81);
        chk(ADDR_ERR_LOW, 8'hff, 8'h23);
        chk(8'h10, 8'hff, 8'h00);
        wr(ADDR_FCE_CTRL, 8'h01);
        chk(ADDR_FCE_CTRL, 8'h10, 8'h00);
        corr_s <= 16'h1234;
        pulse(6'h02);
        repeat (MEAS_CYCLES) @(posedge clk);
        chk(ADDR_FCE_CTRL, 8'h10, 8'h10);
        chk(ADDR_CORR_HIGH, 8'hff, 8'h12);
        cmpv(corr_amt, 16'h1234);
        wr(ADDR_LVL_CFG, 8'h09);
        chk(ADDR_LVL_CFG, 8'hff, 8'h08);
        lvl_s <= 8'h40;
        pulse(6'h01);
        repeat (MEAS_CYCLES) @(posedge clk);
        chk(ADDR_LVL_CFG, 8'hff, 8'h0a);
        chk(ADDR_LVL_READ, 8'hff, 8'h40);
        // Auto mode with auto-zero: entering receive starts a correction from zero.
        wr(ADDR_FCE_CTRL, 8'h0c);
        // The mode moves only once the auto bits have landed, or the entry would pass unseen.
        @(posedge clk);
        mode <= RMQ_RX;
        {gain, lock, osc} <= 3'h7;
        chk(ADDR_FCE_CTRL, 8'h10, 8'h00);
        chk(ADDR_CORR_HIGH, 8'hff, 8'h00);
        repeat (MEAS_CYCLES) @(posedge clk);
        wr(ADDR_FCE_CTRL, 8'h00);
        pulse(6'h01);
        chk(ADDR_FLAGS, 8'hd0, 8'hd0);
        pulse(6'h04);
        chk(ADDR_FLAGS, 8'h04, 8'h04);
        pulse(6'h20);
        chk(ADDR_FLAGS, 8'h04, 8'h00);
        pulse(6'h10);
        wr(ADDR_FLAGS, 8'h01);
        chk(ADDR_FLAGS, 8'h01, 8'h01);
        cont <= 1'b1;
        wr(ADDR_FLAGS, 8'h00);
        chk(ADDR_FLAGS, 8'h01, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        chk(ADDR_FLAGS, 8'h01, 8'h00);
        // Quick wakeup: one sample past the trip point starts the receiver and raises the trip flag.
        trip <= 8'h80;
        pulse(6'h01);
        #1;
        cmpv({15'h0000, rx_go}, 16'h0001);
        chk(ADDR_FLAGS, 8'h08, 8'h08);
        wr(ADDR_FLAGS, 8'h08);
        chk(ADDR_FLAGS, 8'h08, 8'h00);
        pulse(6'h08);
        chk(ADDR_FLAGS, 8'h04, 8'h04);
        mode <= RMQ_STANDBY;
        // Mode ready drops at the change and comes back one cycle later.
        @(posedge clk);
        chk(ADDR_FLAGS, 8'hc4, 8'h80);
        lock <= 1'b0;
        mode <= RMQ_SYNTH;
        chk(ADDR_FLAGS, 8'h90, 8'h00);
        lock <= 1'b1;
        chk(ADDR_FLAGS, 8'h90, 8'h90);
        mode <= RMQ_TX;
        ramp <= 1'b1;
        @(posedge clk);
        chk(ADDR_FLAGS, 8'hb0, 8'hb0);
        mode <= RMQ_SLEEP;
        interm <= 1'b1;
        chk(ADDR_FLAGS, 8'h22, 8'h02);
        interm <= 1'b0;
        chk(ADDR_FLAGS, 8'h02, 8'h00);
        close_out();
    end
endmodule : tb_rx_measure_irq_status_regs
`default_nettype wire
